// ===== design/nit_mdio_top.sv
// Management frame slave for device 31 holding the receiver tuning bank.
`timescale 1ns/1ns
module nit_mdio_top
    import nit_pkg::*;
#(
    parameter logic [4:0] PORT_ADDR = 5'h00
)
(
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic       enhanced_noise_immunity,
    output logic [5:0]      beacon_thr,
    output logic [5:0]      preamble_thr,
    output logic [5:0]      commit_thr,
    output logic [6:0]      drift_window_bt,
    output logic            tune_apply
);

    typedef enum logic [1:0] {
        NIT_S_IDLE = 2'b00,
        NIT_S_HDR  = 2'b01,
        NIT_S_TA   = 2'b10,
        NIT_S_DATA = 2'b11
    } nit_state_e;

    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    logic [1:0]  mdc_sync_reg;
    logic [1:0]  mdio_sync_reg;
    logic        mdc_prev_reg;
    logic        mdc_rise;
    logic        bit_in;
    nit_state_e  state_reg;
    logic [5:0]  pre_cnt_reg;
    logic [3:0]  bit_cnt_reg;
    logic [12:0] hdr_reg;
    logic [12:0] hdr_next;
    logic [1:0]  op_reg;
    logic        match_reg;
    logic        hdr_match;
    logic [15:0] shift_reg;
    logic [15:0] word_next;
    logic [15:0] addr_reg;
    logic        wr_en_reg;
    logic [15:0] wdata_reg;

    nit_reg_if regs ();

    // =====================================================================
    // Reset release and pin synchronisers
    // =====================================================================
    // The reset is released through two flops.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    assign rst_n = rst_sync_reg[1];

    // The clock and data pins pass two flops before any use.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mdc_sync_reg  <= 2'b00;
            mdio_sync_reg <= 2'b11;
            mdc_prev_reg  <= 1'b0;
        end
        else
        begin
            mdc_sync_reg  <= {mdc_sync_reg[0], mdc};
            mdio_sync_reg <= {mdio_sync_reg[0], mdio_in};
            mdc_prev_reg  <= mdc_sync_reg[1];
        end
    end

    // A rising management clock samples one frame bit.
    assign mdc_rise = mdc_sync_reg[1] && !mdc_prev_reg;
    assign bit_in   = mdio_sync_reg[1];

    // =====================================================================
    // Frame decode helpers
    // =====================================================================
    // Header holds ST2, OP, port and device fields once complete.
    assign hdr_next  = {hdr_reg[11:0], bit_in};
    assign hdr_match = !hdr_next[12] && hdr_next[9:5] == PORT_ADDR
                       && hdr_next[4:0] == NIT_DEVAD;
    assign word_next = {shift_reg[14:0], bit_in};

    // =====================================================================
    // Frame state machine
    // =====================================================================
    // Preamble, header, turnaround and data are walked per clock edge.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg   <= NIT_S_IDLE;
            pre_cnt_reg <= 6'h00;
            bit_cnt_reg <= 4'h0;
            hdr_reg     <= 13'h0000;
            op_reg      <= NIT_OP_ADDR;
            match_reg   <= 1'b0;
        end
        else if (mdc_rise)
        begin
            unique case (state_reg)
                NIT_S_IDLE:
                begin
                    bit_cnt_reg <= 4'h0;
                    if (bit_in)
                    begin
                        if (pre_cnt_reg != NIT_PRE_MIN)
                            pre_cnt_reg <= pre_cnt_reg + 6'h01;
                    end
                    else
                    begin
                        pre_cnt_reg <= 6'h00;
                        if (pre_cnt_reg == NIT_PRE_MIN)
                            state_reg <= NIT_S_HDR;
                    end
                end
                NIT_S_HDR:
                begin
                    hdr_reg     <= hdr_next;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == NIT_HDR_LAST)
                    begin
                        op_reg      <= hdr_next[11:10];
                        match_reg   <= hdr_match;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= NIT_S_TA;
                    end
                end
                NIT_S_TA:
                begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg[0])
                    begin
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= NIT_S_DATA;
                    end
                end
                NIT_S_DATA:
                begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == NIT_DATA_LAST)
                    begin
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= NIT_S_IDLE;
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // Data shifter and address pointer
    // =====================================================================
    // Reads are fetched at header end; addresses load or advance.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg <= 16'h0000;
            addr_reg  <= 16'h0000;
            wr_en_reg <= 1'b0;
            wdata_reg <= 16'h0000;
        end
        else
        begin
            wr_en_reg <= 1'b0;
            if (mdc_rise && state_reg == NIT_S_HDR
                && bit_cnt_reg == NIT_HDR_LAST)
                shift_reg <= regs.rdata;
            else if (mdc_rise && state_reg == NIT_S_DATA)
            begin
                shift_reg <= word_next;
                if (bit_cnt_reg == NIT_DATA_LAST && match_reg)
                begin
                    if (op_reg == NIT_OP_ADDR)
                        addr_reg <= word_next;
                    else if (op_reg == NIT_OP_WRITE)
                    begin
                        wr_en_reg <= 1'b1;
                        wdata_reg <= word_next;
                    end
                    else if (op_reg == NIT_OP_RD_INC)
                        addr_reg <= addr_reg + 16'h0001;
                end
            end
        end
    end

    // =====================================================================
    // Pin drive
    // =====================================================================
    // The pin is driven low in turnaround bit two, then data MSB first.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mdio_out <= 1'b1;
            mdio_oe  <= 1'b0;
        end
        else if (mdc_rise)
        begin
            if (state_reg == NIT_S_TA && match_reg && op_reg[1])
            begin
                mdio_oe  <= 1'b1;
                mdio_out <= bit_cnt_reg[0] ? shift_reg[15] : 1'b0;
            end
            else if (state_reg == NIT_S_DATA && mdio_oe
                     && bit_cnt_reg != NIT_DATA_LAST)
                mdio_out <= shift_reg[14];
            else
            begin
                mdio_oe  <= 1'b0;
                mdio_out <= 1'b1;
            end
        end
    end

    // =====================================================================
    // Register bank
    // =====================================================================
    // The bank sees the held address; writes are one-cycle strobes.
    assign regs.wr_en = wr_en_reg;
    assign regs.addr  = addr_reg;
    assign regs.wdata = wdata_reg;

    nit_regbank u_bank (
        .core_clk                (core_clk),
        .rst_n                   (rst_n),
        .bus                     (regs.slave),
        .enhanced_noise_immunity (enhanced_noise_immunity),
        .beacon_thr              (beacon_thr),
        .preamble_thr            (preamble_thr),
        .commit_thr              (commit_thr),
        .drift_window_bt         (drift_window_bt),
        .tune_apply              (tune_apply)
    );

endmodule : nit_mdio_top

// ===== design/nit_pkg.sv
// Constants shared by the noise immunity tuning register bank.
package nit_pkg;

    // =====================================================================
    // Management frame layout
    // =====================================================================
    localparam logic [5:0]  NIT_PRE_MIN     = 6'h20; // Preamble ones needed.
    localparam logic [3:0]  NIT_HDR_LAST    = 4'hc;  // Header bits after ST.
    localparam logic [3:0]  NIT_DATA_LAST   = 4'hf;  // Data bits minus one.
    localparam logic [1:0]  NIT_OP_ADDR     = 2'h0;
    localparam logic [1:0]  NIT_OP_WRITE    = 2'h1;
    localparam logic [1:0]  NIT_OP_RD_INC   = 2'h2;
    localparam logic [1:0]  NIT_OP_READ     = 2'h3;
    localparam logic [4:0]  NIT_DEVAD       = 5'h1f; // Vendor device 31.

    // =====================================================================
    // Register addresses inside device 31
    // =====================================================================
    localparam logic [15:0] NIT_ADDR_TUNE0  = 16'h8003;
    localparam logic [15:0] NIT_ADDR_TUNE1  = 16'h8004;
    localparam logic [15:0] NIT_ADDR_IDENT  = 16'hca00;

    // =====================================================================
    // Field positions and reset values
    // =====================================================================
    localparam int          NIT_THR_W       = 6;
    localparam int          NIT_HI_LSB      = 8;     // Fields at 13:8.
    localparam int          NIT_LO_LSB      = 0;     // Field at 5:0.
    localparam int          NIT_DRIFT_LSB   = 0;     // Code field at 2:0.
    localparam int          NIT_DRIFT_W     = 3;
    localparam logic [5:0]  NIT_BEACON_RST  = 6'h20;
    localparam logic [5:0]  NIT_PREAMB_RST  = 6'h35;
    localparam logic [5:0]  NIT_COMMIT_RST  = 6'h20;
    localparam logic [2:0]  NIT_DRIFT_RST   = 3'h5;

    // =====================================================================
    // Drift window codes and sizes in bit times
    // =====================================================================
    localparam logic [2:0]  NIT_DW_31       = 3'h2;
    localparam logic [2:0]  NIT_DW_63       = 3'h3;
    localparam logic [2:0]  NIT_DW_127      = 3'h4;
    localparam logic [6:0]  NIT_BT_31       = 7'h1f;
    localparam logic [6:0]  NIT_BT_63       = 7'h3f;
    localparam logic [6:0]  NIT_BT_127      = 7'h7f;

endpackage : nit_pkg

// ===== design/nit_reg_if.sv
// Register access channel between the frame engine and the register bank.
`timescale 1ns/1ns
interface nit_reg_if;
    logic        wr_en;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    // The frame engine issues accesses.
    modport master (output wr_en, output addr, output wdata, input rdata);
    // The bank stores and answers them.
    modport slave  (input wr_en, input addr, input wdata, output rdata);
endinterface : nit_reg_if

// ===== design/nit_regbank.sv
// Tuning and identification registers with receiver-facing outputs.
`timescale 1ns/1ns
module nit_regbank
    import nit_pkg::*;
#(
    parameter logic [7:0] MAP_ID      = 8'h5a, // Arbitrary identifier.
    parameter logic [7:0] MAP_VERSION = 8'h01, // Arbitrary version.
    parameter logic [6:0] DRIFT_OPT   = 7'h3f  // Optimized window size.
)
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    nit_reg_if.slave        bus,
    input  wire logic       enhanced_noise_immunity,
    output logic [5:0]      beacon_thr,
    output logic [5:0]      preamble_thr,
    output logic [5:0]      commit_thr,
    output logic [6:0]      drift_window_bt,
    output logic            tune_apply
);

    logic [5:0] beacon_reg;
    logic [5:0] preamble_reg;
    logic [5:0] commit_reg;
    logic [2:0] drift_reg;
    logic [6:0] window_next;

    // =====================================================================
    // Stored fields
    // =====================================================================
    // Writes keep only the defined fields; unused bits are dropped.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            beacon_reg   <= NIT_BEACON_RST;
            drift_reg    <= NIT_DRIFT_RST;
            preamble_reg <= NIT_PREAMB_RST;
            commit_reg   <= NIT_COMMIT_RST;
        end
        else if (bus.wr_en && bus.addr == NIT_ADDR_TUNE0)
        begin
            beacon_reg <= bus.wdata[NIT_HI_LSB +: NIT_THR_W];
            drift_reg  <= bus.wdata[NIT_DRIFT_LSB +: NIT_DRIFT_W];
        end
        else if (bus.wr_en && bus.addr == NIT_ADDR_TUNE1)
        begin
            preamble_reg <= bus.wdata[NIT_HI_LSB +: NIT_THR_W];
            commit_reg   <= bus.wdata[NIT_LO_LSB +: NIT_THR_W];
        end
    end

    // =====================================================================
    // Read mux
    // =====================================================================
    // Unused bits read as zero; the identifier is constant.
    always_comb
    begin
        bus.rdata = 16'h0000;
        unique case (bus.addr)
            NIT_ADDR_TUNE0:
            begin
                bus.rdata[NIT_HI_LSB +: NIT_THR_W]     = beacon_reg;
                bus.rdata[NIT_DRIFT_LSB +: NIT_DRIFT_W] = drift_reg;
            end
            NIT_ADDR_TUNE1:
            begin
                bus.rdata[NIT_HI_LSB +: NIT_THR_W] = preamble_reg;
                bus.rdata[NIT_LO_LSB +: NIT_THR_W] = commit_reg;
            end
            NIT_ADDR_IDENT:
                bus.rdata = {MAP_ID, MAP_VERSION};
            default:
                bus.rdata = 16'h0000;
        endcase
    end

    // =====================================================================
    // Drift window decode
    // =====================================================================
    // Larger codes give wider windows; reserved codes fall back.
    always_comb
    begin
        unique case (drift_reg)
            NIT_DW_31:  window_next = NIT_BT_31;
            NIT_DW_63:  window_next = NIT_BT_63;
            NIT_DW_127: window_next = NIT_BT_127;
            default:    window_next = DRIFT_OPT;
        endcase
    end

    // =====================================================================
    // Receiver outputs
    // =====================================================================
    // Thresholds pass unchanged so larger values stay stricter.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            beacon_thr      <= NIT_BEACON_RST;
            preamble_thr    <= NIT_PREAMB_RST;
            commit_thr      <= NIT_COMMIT_RST;
            drift_window_bt <= DRIFT_OPT;
            tune_apply      <= 1'b0;
        end
        else
        begin
            beacon_thr      <= beacon_reg;
            preamble_thr    <= preamble_reg;
            commit_thr      <= commit_reg;
            drift_window_bt <= window_next;
            tune_apply      <= enhanced_noise_immunity;
        end
    end

endmodule : nit_regbank

// ===== verif/nit_mdio_checker.sv
// Port-level assertions for the management register bank top.
`timescale 1ns/1ns
module nit_mdio_checker
(
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       mdc,
    input wire logic       mdio_in,
    input wire logic       mdio_out,
    input wire logic       mdio_oe,
    input wire logic       enhanced_noise_immunity,
    input wire logic [5:0] beacon_thr,
    input wire logic [5:0] preamble_thr,
    input wire logic [5:0] commit_thr,
    input wire logic [6:0] drift_window_bt,
    input wire logic       tune_apply
);
    logic       mdc_q;
    logic [4:0] oe_rises;
    logic [7:0] since_mdc;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // =====================================================================
    // Helper counters
    // =====================================================================
    // Counts mdc rises while driving and cycles since the last mdc rise.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mdc_q     <= 1'b0;
            oe_rises  <= 5'h00;
            since_mdc <= 8'h00;
        end
        else
        begin
            mdc_q <= mdc;
            if (!mdio_oe)
                oe_rises <= 5'h00;
            else if (mdc && !mdc_q)
                oe_rises <= oe_rises + 5'h01;
            if (mdc && !mdc_q)
                since_mdc <= 8'h00;
            else if (since_mdc != 8'hff)
                since_mdc <= since_mdc + 8'h01;
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    sequence mode_on3;
        enhanced_noise_immunity [*3];
    endsequence
    sequence mode_off3;
        !enhanced_noise_immunity [*3];
    endsequence

    tune_on_a: assert property (mode_on3 |=> tune_apply)
        else $error("tune_apply low while enhanced mode held on");
    tune_off_a: assert property (mode_off3 |=> !tune_apply)
        else $error("tune_apply high while enhanced mode held off");
    oe_start_a: assert property ($rose(mdio_oe) |->
        since_mdc < 8'h08 && !mdio_out)
        else $error("drive did not start with a zero after mdc rise");
    oe_run_a: assert property ($rose(mdio_oe) |-> mdio_oe [*8])
        else $error("drive ended too early");
    oe_len_a: assert property ($fell(mdio_oe) |-> oe_rises == 5'h11)
        else $error("drive did not last seventeen mdc periods");
    out_idle_a: assert property (!mdio_oe |-> mdio_out)
        else $error("data out not high while released");
    thr_quiet_a: assert property (!$stable({beacon_thr, preamble_thr,
        commit_thr, drift_window_bt}) |-> since_mdc < 8'h10)
        else $error("tuning output changed away from a frame");
    drift_code_a: assert property (drift_window_bt inside
        {7'h1f, 7'h3f, 7'h7f})
        else $error("drift window size not a legal value");
endmodule : nit_mdio_checker

bind nit_mdio_top nit_mdio_checker i_nit_mdio_checker (
    .core_clk(core_clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .enhanced_noise_immunity(enhanced_noise_immunity),
    .beacon_thr(beacon_thr), .preamble_thr(preamble_thr),
    .commit_thr(commit_thr), .drift_window_bt(drift_window_bt),
    .tune_apply(tune_apply));

// ===== verif/nit_sta_model.sv
// Station manager model that runs management frames on mdc and mdio.
`timescale 1ns/1ns
module nit_sta_model
    import nit_pkg::*;
(
    input  wire logic core_clk,
    output logic      mdc,
    output logic      host_oe,
    output logic      host_out,
    input  wire logic mdio_line
);
    // =====================================================================
    // Frame engine
    // =====================================================================
    // Idle: clock parked low and the line left to its pull-up.
    initial
    begin
        mdc      = 1'b0;
        host_oe  = 1'b0;
        host_out = 1'b0;
    end

    // One mdc period of 16 core clocks; the line is sampled at the rise.
    task automatic tick(input logic b, output logic s);
        host_out = b;
        repeat (8) @(negedge core_clk);
        mdc = 1'b1;
        s   = mdio_line;
        repeat (8) @(negedge core_clk);
        mdc = 1'b0;
    endtask : tick

    // One whole frame: preamble, header, turnaround and a 16-bit word.
    task automatic xfer(input logic [1:0] op, input logic [4:0] dev,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        s;
        hdr     = {2'b00, op, 5'h00, dev};
        rd      = 16'hffff;
        host_oe = 1'b1;
        repeat (32) tick(1'b1, s);
        for (int i = 13; i >= 0; i--)
            tick(hdr[i], s);
        if (op[1])
        begin
            host_oe = 1'b0;
            repeat (2) tick(1'b1, s);
            for (int i = 15; i >= 0; i--)
            begin
                tick(1'b1, s);
                rd[i] = s;
            end
        end
        else
        begin
            tick(1'b1, s);
            tick(1'b0, s);
            for (int i = 15; i >= 0; i--)
                tick(wd[i], s);
        end
        host_oe = 1'b0;
        repeat (16) @(negedge core_clk);
    endtask : xfer
endmodule : nit_sta_model

// ===== verif/nit_mdio_top_test.sv
// Self-checking bench for the management register bank top.
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %0t got=%h exp=%h", $time, g, e); end end
module nit_mdio_top_test;
    import nit_pkg::*;
    localparam logic [15:0] IDENT_EXP = 16'h5a01; // Arbitrary bank code.
    logic        core_clk;
    logic        nrst;
    logic        mdc;
    logic        host_oe;
    logic        host_out;
    logic        mdio_line;
    logic        mdio_out;
    logic        mdio_oe;
    logic        enhanced_noise_immunity;
    logic [5:0]  beacon_thr;
    logic [5:0]  preamble_thr;
    logic [5:0]  commit_thr;
    logic [6:0]  drift_window_bt;
    logic        tune_apply;
    int          err_count;
    int          samples_checked;

    // Wire level: device first, then host, else the pull-up.
    assign mdio_line = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);

    nit_mdio_top i_nit_mdio_top (.core_clk(core_clk), .nrst(nrst),
        .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .enhanced_noise_immunity(enhanced_noise_immunity),
        .beacon_thr(beacon_thr), .preamble_thr(preamble_thr),
        .commit_thr(commit_thr), .drift_window_bt(drift_window_bt),
        .tune_apply(tune_apply));
    nit_sta_model i_nit_sta_model (.core_clk(core_clk), .mdc(mdc),
        .host_oe(host_oe), .host_out(host_out), .mdio_line(mdio_line));

    // =====================================================================
    // Access tasks
    // =====================================================================
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] r;
        i_nit_sta_model.xfer(NIT_OP_ADDR, NIT_DEVAD, a, r);
        i_nit_sta_model.xfer(NIT_OP_WRITE, NIT_DEVAD, d, r);
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] r;
        i_nit_sta_model.xfer(NIT_OP_ADDR, NIT_DEVAD, a, r);
        i_nit_sta_model.xfer(NIT_OP_READ, NIT_DEVAD, 16'h0000, r);
        `CHK(r, e)
    endtask : rd_chk

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_reset_vals();
        `CHK(beacon_thr, 6'h20)
        `CHK(preamble_thr, 6'h35)
        `CHK(commit_thr, 6'h20)
        `CHK(drift_window_bt, 7'h3f)
        `CHK(tune_apply, 1'b0)
        rd_chk(16'h8003, 16'h2005);
        rd_chk(16'h8004, 16'h3520);
        rd_chk(16'hca00, IDENT_EXP);
    endtask : t_reset_vals

    // All-ones writes leave unused bits clear; fields land separately.
    task automatic t_fields();
        wr(16'h8003, 16'hffff);
        rd_chk(16'h8003, 16'h3f07);
        `CHK(beacon_thr, 6'h3f)
        wr(16'h8004, 16'hffff);
        rd_chk(16'h8004, 16'h3f3f);
        wr(16'h8004, 16'h0102);
        `CHK(preamble_thr, 6'h01)
        `CHK(commit_thr, 6'h02)
        `CHK(beacon_thr, 6'h3f)
    endtask : t_fields

    // Every drift code, reserved ones falling back to the default size.
    task automatic t_drift();
        logic [6:0]  exp_bt [8];
        logic [15:0] d;
        exp_bt = '{7'h3f, 7'h3f, 7'h1f, 7'h3f, 7'h7f, 7'h3f, 7'h3f, 7'h3f};
        for (int c = 0; c < 8; c++)
        begin
            d = {8'h0a, 5'h00, 3'(c)};
            wr(16'h8003, d);
            `CHK(drift_window_bt, exp_bt[c])
            rd_chk(16'h8003, d);
        end
        `CHK(beacon_thr, 6'h0a)
    endtask : t_drift

    task automatic t_ident();
        wr(16'hca00, 16'h0000);
        rd_chk(16'hca00, IDENT_EXP);
        rd_chk(16'h1234, 16'h0000);
    endtask : t_ident

    // Frames for another device are ignored and never answered.
    task automatic t_refused();
        logic [15:0] r;
        i_nit_sta_model.xfer(NIT_OP_ADDR, 5'h1e, 16'h8003, r);
        i_nit_sta_model.xfer(NIT_OP_WRITE, 5'h1e, 16'h0000, r);
        `CHK(beacon_thr, 6'h0a)
        i_nit_sta_model.xfer(NIT_OP_READ, 5'h1e, 16'h0000, r);
        `CHK(r, 16'hffff)
    endtask : t_refused

    // A read with increment answers, then steps to the next register.
    task automatic t_rd_inc();
        logic [15:0] r;
        i_nit_sta_model.xfer(NIT_OP_ADDR, NIT_DEVAD, 16'h8003, r);
        i_nit_sta_model.xfer(NIT_OP_RD_INC, NIT_DEVAD, 16'h0000, r);
        `CHK(r, 16'h0a07)
        i_nit_sta_model.xfer(NIT_OP_READ, NIT_DEVAD, 16'h0000, r);
        `CHK(r, 16'h0102)
    endtask : t_rd_inc

    task automatic t_tune();
        @(negedge core_clk);
        enhanced_noise_immunity = 1'b1;
        repeat (4) @(negedge core_clk);
        `CHK(tune_apply, 1'b1)
        enhanced_noise_immunity = 1'b0;
        repeat (4) @(negedge core_clk);
        `CHK(tune_apply, 1'b0)
    endtask : t_tune

    // =====================================================================
    // Run control
    // =====================================================================
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Sixty frames of about a thousand cycles each fit well inside this.
    initial
    begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        summarize();
    end

    initial
    begin
        err_count               = 0;
        samples_checked         = 0;
        nrst                    = 1'b0;
        enhanced_noise_immunity = 1'b0;
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset_vals();
        t_tune();
        t_fields();
        t_drift();
        t_ident();
        t_refused();
        t_rd_inc();
        summarize();
    end
endmodule : nit_mdio_top_test
